//--- logic/sdc_map.svh
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH
// register byte offsets
`define SDC_OFS_PRIM_CTRL    12'h000
`define SDC_OFS_AUX_CTRL     12'h004
`define SDC_OFS_CUR_CTRL     12'h008
`define SDC_OFS_RATE         12'h00C
`define SDC_OFS_STATUS       12'h010
`define SDC_OFS_CAL_CMD      12'h014
`define SDC_OFS_PRIM_DATA    12'h018
`define SDC_OFS_AUX_DATA     12'h01C
`define SDC_OFS_PRIM_OFFS    12'h020
`define SDC_OFS_PRIM_GAIN    12'h024
`define SDC_OFS_AUX_OFFS     12'h028
`define SDC_OFS_AUX_GAIN     12'h02C
// converter control fields
`define SDC_CTL_RANGE_LSB    0
`define SDC_CTL_UNIPOLAR     3
`define SDC_CTL_EXT_REF      4
// current source control fields
`define SDC_CUR_SRC1_ON      0
`define SDC_CUR_SRC2_ON      1
`define SDC_CUR_SRC1_PIN     2
`define SDC_CUR_SRC2_PIN     3
`define SDC_CUR_BURNOUT      4
// status fields
`define SDC_ST_PRIM_RDY      0
`define SDC_ST_AUX_RDY       1
`define SDC_ST_PRIM_ERR      2
`define SDC_ST_AUX_ERR       3
`define SDC_ST_NOREF         4
`define SDC_ST_PRIM_BUSY     5
`define SDC_ST_AUX_BUSY      6
// calibration command fields
`define SDC_CAL_START        0
`define SDC_CAL_GAIN         1
`define SDC_CAL_AUX          2
// reset values
`define SDC_RST_RATE         8'h45
`define SDC_RST_CTRL         5'h00
`define SDC_RST_CUR          5'h00
`define SDC_RST_CODE         16'h0000
`endif

//--- logic/sdc_pkg.sv
package sdc_pkg;
  // settings that reach the analog side of one converter
  typedef struct packed {
    logic       ext_ref;
    logic       unipolar;
    logic [2:0] gain_range;
  } sdc_conv_cfg_type;

  // excitation and burnout switch settings
  typedef struct packed {
    logic burnout_enable;
    logic exc_source2_pin_select;
    logic exc_source1_pin_select;
    logic exc_source2_on;
    logic exc_source1_on;
  } sdc_cur_cfg_type;

  // calibration state of one converter
  typedef struct packed {
    logic busy;
    logic gain;
    logic bad;
  } sdc_cal_type;
endpackage : sdc_pkg

//--- logic/sdc_ctrl.sv
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ns
`include "sdc_map.svh"
module sdc_ctrl (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [1:0]                filt_valid,
  input  wire logic signed [17:0]        filt_word_prim,
  input  wire logic signed [17:0]        filt_word_aux,
  input  wire logic                      ref_below_min,
  input  wire logic                      ref_open,
  output sdc_pkg::sdc_conv_cfg_type      prim_cfg,
  output sdc_pkg::sdc_conv_cfg_type      aux_cfg,
  output sdc_pkg::sdc_cur_cfg_type       cur_cfg,
  output logic      [1:0]                excitation_pin_a,
  output logic      [1:0]                excitation_pin_b,
  output logic      [7:0]                filter_rate_word,
  output logic                           no_valid_reference_flag
);
  logic                           pready_ff;
  logic [31:0]                    prdata_ff;
  logic                           pslverr_ff;
  sdc_pkg::sdc_conv_cfg_type      ctrl_ff [2];
  sdc_pkg::sdc_conv_cfg_type      active_ff [2];
  sdc_pkg::sdc_cur_cfg_type       cur_ff;
  logic [1:0]                     pin_a_ff;
  logic [1:0]                     pin_b_ff;
  logic [7:0]                     rate_ff;
  logic [2:0]                     ref_sync_ff;
  logic                           noref_ff;
  logic signed [17:0]             prev_ff [2];
  logic [1:0]                     have_prev_ff;
  logic [15:0]                    data_ff [2];
  logic [15:0]                    offs_ff [2];
  logic [15:0]                    gain_ff [2];
  logic [1:0]                     rdy_ff;
  logic [1:0]                     err_ff;
  sdc_pkg::sdc_cal_type           cal_ff [2];
  logic                           access;
  logic                           wr_en;
  logic                           rd_en;
  logic signed [17:0]             word [2];
  logic [1:0]                     res_evt;
  logic [15:0]                    res_code [2];
  logic [1:0]                     cal_start;
  logic [1:0]                     data_rd;
  logic                           mapped;
  logic [31:0]                    rd_mux;

  // output coding of one averaged filter word
  function automatic logic [15:0] code_fn(input logic signed [17:0] avg,
                                          input logic              uni);
    logic signed [18:0] t;
    t = 19'(avg) + 19'sh1_0000;
    if (uni) begin
      if (avg < 0) code_fn = 16'h0000;
      else if (avg > 18'sh0_FFFF) code_fn = 16'hFFFF;
      else code_fn = avg[15:0];
    end else begin
      if (t < 0) code_fn = 16'h0000;
      else if (t > 19'sh1_FFFF) code_fn = 16'hFFFF;
      else code_fn = t[16:1];
    end
  endfunction : code_fn

  // average of two signed filter words
  function automatic logic signed [17:0] avg_fn(input logic signed [17:0] a,
                                                input logic signed [17:0] b);
    logic signed [18:0] s;
    s = 19'(a) + 19'(b);
    avg_fn = s[18:1];
  endfunction : avg_fn

  // apb decode: one wait state, answer registered
  assign access = psel & penable;
  assign wr_en  = access & pready_ff & pwrite;
  assign rd_en  = access & pready_ff & ~pwrite;
  assign word[0] = filt_word_prim;
  assign word[1] = filt_word_aux;
  assign cal_start[0] = wr_en & (paddr == `SDC_OFS_CAL_CMD) & pwdata[`SDC_CAL_START]
                        & ~pwdata[`SDC_CAL_AUX];
  assign cal_start[1] = wr_en & (paddr == `SDC_OFS_CAL_CMD) & pwdata[`SDC_CAL_START]
                        & pwdata[`SDC_CAL_AUX];
  assign data_rd[0] = rd_en & (paddr == `SDC_OFS_PRIM_DATA);
  assign data_rd[1] = rd_en & (paddr == `SDC_OFS_AUX_DATA);

  // result event and its code per converter
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      res_evt[c]  = filt_valid[c] & have_prev_ff[c];
      res_code[c] = noref_ff ? 16'hFFFF :
                    code_fn(avg_fn(prev_ff[c], word[c]), active_ff[c].unipolar);
    end
  end

  // read mux
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `SDC_OFS_PRIM_CTRL: rd_mux[4:0] = ctrl_ff[0];
      `SDC_OFS_AUX_CTRL:  rd_mux[4:0] = ctrl_ff[1];
      `SDC_OFS_CUR_CTRL:  rd_mux[4:0] = cur_ff;
      `SDC_OFS_RATE:      rd_mux[7:0] = rate_ff;
      `SDC_OFS_STATUS:    rd_mux[6:0] = {cal_ff[1].busy, cal_ff[0].busy, noref_ff,
                                         err_ff[1], err_ff[0], rdy_ff[1], rdy_ff[0]};
      `SDC_OFS_CAL_CMD:   rd_mux[2:0] = 3'h0;
      `SDC_OFS_PRIM_DATA: rd_mux[15:0] = data_ff[0];
      `SDC_OFS_AUX_DATA:  rd_mux[15:0] = data_ff[1];
      `SDC_OFS_PRIM_OFFS: rd_mux[15:0] = offs_ff[0];
      `SDC_OFS_PRIM_GAIN: rd_mux[15:0] = gain_ff[0];
      `SDC_OFS_AUX_OFFS:  rd_mux[15:0] = offs_ff[1];
      `SDC_OFS_AUX_GAIN:  rd_mux[15:0] = gain_ff[1];
      default:            mapped = 1'b0;
    endcase
  end

  // apb handshake and registered answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= access & ~pready_ff;
      prdata_ff  <= (access & ~pready_ff & ~pwrite) ? rd_mux : 32'h0000_0000;
      pslverr_ff <= access & ~pready_ff & ~mapped;
    end
  end

  // software control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff[0] <= `SDC_RST_CTRL;
      ctrl_ff[1] <= `SDC_RST_CTRL;
      cur_ff     <= `SDC_RST_CUR;
      rate_ff    <= `SDC_RST_RATE;
    end else if (wr_en) begin
      case (paddr)
        `SDC_OFS_PRIM_CTRL: ctrl_ff[0] <= pwdata[4:0];
        `SDC_OFS_AUX_CTRL:  ctrl_ff[1] <= {pwdata[`SDC_CTL_EXT_REF],
                                           pwdata[`SDC_CTL_UNIPOLAR], 3'h0};
        `SDC_OFS_CUR_CTRL:  cur_ff <= pwdata[4:0];
        `SDC_OFS_RATE:      rate_ff <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // settings applied at each conversion cycle boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_ff[0] <= `SDC_RST_CTRL;
      active_ff[1] <= `SDC_RST_CTRL;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (filt_valid[c]) active_ff[c] <= ctrl_ff[c];
      end
    end
  end

  // excitation routing: count of sources on each pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_a_ff <= 2'h0;
      pin_b_ff <= 2'h0;
    end else begin
      pin_a_ff <= 2'({1'b0, cur_ff.exc_source1_on & ~cur_ff.exc_source1_pin_select}
                  + {1'b0, cur_ff.exc_source2_on & cur_ff.exc_source2_pin_select});
      pin_b_ff <= 2'({1'b0, cur_ff.exc_source1_on & cur_ff.exc_source1_pin_select}
                  + {1'b0, cur_ff.exc_source2_on & ~cur_ff.exc_source2_pin_select});
    end
  end

  // reference detector synchroniser, change taken once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_sync_ff <= 3'h0;
      noref_ff    <= 1'b0;
    end else begin
      ref_sync_ff <= {ref_sync_ff[1:0], ref_below_min | ref_open};
      if (ref_sync_ff[1] == ref_sync_ff[2]) noref_ff <= ref_sync_ff[2];
    end
  end

  // averaging pipeline per converter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff[0]   <= 18'sh0_0000;
      prev_ff[1]   <= 18'sh0_0000;
      have_prev_ff <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (cal_start[c]) have_prev_ff[c] <= 1'b0;
        else if (filt_valid[c]) begin
          prev_ff[c]      <= word[c];
          have_prev_ff[c] <= (ctrl_ff[c] == active_ff[c]);
        end
      end
    end
  end

  // result, ready flag and calibration sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 2; c++) begin
        data_ff[c] <= `SDC_RST_CODE;
        offs_ff[c] <= `SDC_RST_CODE;
        gain_ff[c] <= `SDC_RST_CODE;
        cal_ff[c]  <= 3'h0;
      end
      rdy_ff <= 2'h0;
      err_ff <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        // ready set wins over clear-on-read
        if (res_evt[c]) rdy_ff[c] <= 1'b1;
        else if (data_rd[c] | cal_start[c]) rdy_ff[c] <= 1'b0;
        if (cal_start[c]) begin
          cal_ff[c].busy <= 1'b1;
          cal_ff[c].gain <= pwdata[`SDC_CAL_GAIN];
          cal_ff[c].bad  <= noref_ff;
          err_ff[c]      <= 1'b0;
        end else if (cal_ff[c].busy) begin
          if (noref_ff) cal_ff[c].bad <= 1'b1;
          if (res_evt[c]) begin
            cal_ff[c].busy <= 1'b0;
            if (cal_ff[c].bad | noref_ff) err_ff[c] <= 1'b1;
            else if (cal_ff[c].gain) gain_ff[c] <= res_code[c];
            else offs_ff[c] <= res_code[c];
          end
        end else if (res_evt[c]) begin
          data_ff[c] <= res_code[c];
        end
      end
    end
  end

  assign prdata                  = prdata_ff;
  assign pready                  = pready_ff;
  assign pslverr                 = pslverr_ff;
  assign prim_cfg                = active_ff[0];
  assign aux_cfg                 = active_ff[1];
  assign cur_cfg                 = cur_ff;
  assign excitation_pin_a        = pin_a_ff;
  assign excitation_pin_b        = pin_b_ff;
  assign filter_rate_word        = rate_ff;
  assign no_valid_reference_flag = noref_ff;

  // helper: rate word written since reset
  logic rate_written_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rate_written_ff <= 1'b0;
    else if (wr_en && paddr == `SDC_OFS_RATE) rate_written_ff <= 1'b1;
  end

  sequence s_cur_write;
    wr_en && paddr == `SDC_OFS_CUR_CTRL;
  endsequence
  sequence s_cal_bad_end(int c);
    cal_ff[c].busy && res_evt[c] && (cal_ff[c].bad || noref_ff);
  endsequence

  property p_rate_reset;
    @(posedge pclk) disable iff (!presetn)
    !rate_written_ff |-> rate_ff == 8'h45;
  endproperty
  a_rate_reset: assert property (p_rate_reset) else $error("rate word not at reset value");

  property p_burnout;
    @(posedge pclk) disable iff (!presetn)
    s_cur_write ##1 1'b1 |-> cur_cfg.burnout_enable == $past(pwdata[`SDC_CUR_BURNOUT]);
  endproperty
  a_burnout: assert property (p_burnout) else $error("burnout switch not following write");

  property p_exc_route;
    @(posedge pclk) disable iff (!presetn)
    s_cur_write ##2 1'b1 |-> (excitation_pin_a + excitation_pin_b) ==
      ($past(pwdata[`SDC_CUR_SRC1_ON], 2) + $past(pwdata[`SDC_CUR_SRC2_ON], 2));
  endproperty
  a_exc_route: assert property (p_exc_route) else $error("excitation sources lost");

  property p_noref_follow;
    @(posedge pclk) disable iff (!presetn)
    (ref_sync_ff[1] == ref_sync_ff[2]) ##1 1'b1 |-> noref_ff == $past(ref_sync_ff[2]);
  endproperty
  a_noref_follow: assert property (p_noref_follow) else $error("reference flag not following");

  property p_noref_ones;
    @(posedge pclk) disable iff (!presetn)
    res_evt[0] && !cal_ff[0].busy && noref_ff |=> data_ff[0] == 16'hFFFF;
  endproperty
  a_noref_ones: assert property (p_noref_ones) else $error("result not forced to all ones");

  property p_cal_block;
    @(posedge pclk) disable iff (!presetn)
    s_cal_bad_end(0) |=> err_ff[0] && $stable(offs_ff[0]) && $stable(gain_ff[0]);
  endproperty
  a_cal_block: assert property (p_cal_block) else $error("bad calibration updated coefficients");

  property p_cfg_boundary;
    @(posedge pclk) disable iff (!presetn)
    $changed(prim_cfg) |-> $past(filt_valid[0]);
  endproperty
  a_cfg_boundary: assert property (p_cfg_boundary) else $error("settings changed mid cycle");

  property p_first_result;
    @(posedge pclk) disable iff (!presetn)
    filt_valid[0] && !have_prev_ff[0] |=> !rdy_ff[0] || $past(rdy_ff[0]);
  endproperty
  a_first_result: assert property (p_first_result) else $error("result from single output");

  property p_aux_fixed;
    @(posedge pclk) disable iff (!presetn)
    aux_cfg.gain_range == 3'h0;
  endproperty
  a_aux_fixed: assert property (p_aux_fixed) else $error("aux range not fixed");

  property p_unipolar_mid;
    @(posedge pclk) disable iff (!presetn)
    res_evt[1] && !noref_ff && !cal_ff[1].busy && active_ff[1].unipolar &&
      avg_fn(prev_ff[1], word[1]) == 18'sh0_8000 |=> data_ff[1] == 16'h8000;
  endproperty
  a_unipolar_mid: assert property (p_unipolar_mid) else $error("unipolar midscale code wrong");

  property p_bipolar_zero;
    @(posedge pclk) disable iff (!presetn)
    res_evt[1] && !noref_ff && !cal_ff[1].busy && !active_ff[1].unipolar &&
      avg_fn(prev_ff[1], word[1]) == 18'sh0_0000 |=> data_ff[1] == 16'h8000;
  endproperty
  a_bipolar_zero: assert property (p_bipolar_zero) else $error("bipolar zero code wrong");
endmodule : sdc_ctrl

//--- tb/tb.sv
`timescale 1ns/1ns
`include "sdc_map.svh"
module tb;
  logic                      pclk;
  logic                      presetn;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic [11:0]               paddr;
  logic [31:0]               pwdata;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic [1:0]                filt_valid;
  logic signed [17:0]        filt_word_prim;
  logic signed [17:0]        filt_word_aux;
  logic                      ref_below_min;
  logic                      ref_open;
  sdc_pkg::sdc_conv_cfg_type prim_cfg;
  sdc_pkg::sdc_conv_cfg_type aux_cfg;
  sdc_pkg::sdc_cur_cfg_type  cur_cfg;
  logic [1:0]                excitation_pin_a;
  logic [1:0]                excitation_pin_b;
  logic [7:0]                filter_rate_word;
  logic                      no_valid_reference_flag;
  logic [31:0]               rdat;
  logic                      rerr;
  logic [31:0]               keep;
  int                        err_count;
  int                        n_compared;
  int                        cyc;

  sdc_ctrl u_sdc_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .filt_valid(filt_valid), .filt_word_prim(filt_word_prim), .filt_word_aux(filt_word_aux),
    .ref_below_min(ref_below_min), .ref_open(ref_open), .prim_cfg(prim_cfg),
    .aux_cfg(aux_cfg), .cur_cfg(cur_cfg), .excitation_pin_a(excitation_pin_a),
    .excitation_pin_b(excitation_pin_b), .filter_rate_word(filter_rate_word),
    .no_valid_reference_flag(no_valid_reference_flag)
  );

  // 250 MHz clock
  initial pclk = 1'b0;
  always #2 pclk = ~pclk;

  task final_report;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      final_report();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is seen high at an edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // filter output pulses on the chosen converters
  task pulse(input logic [1:0] m, input int n);
    repeat (n) begin
      @(posedge pclk);
      filt_valid <= m;
      @(posedge pclk);
      filt_valid <= 2'b00;
      repeat (3) @(posedge pclk);
    end
  endtask : pulse

  task settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  logic [31:0] ctab [6];
  logic [17:0] wtab [6];
  logic [15:0] etab [6];
  logic [1:0]  ea;
  logic [1:0]  eb;

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {filt_valid, filt_word_prim, filt_word_aux, ref_below_min, ref_open} = '0;
    err_count = 0; n_compared = 0; cyc = 0; presetn = 1'b0;
    ctab = '{32'h0000_0008, 32'h0000_0008, 32'h0000_0008, 32'h0000_0000, 32'h0000_0000,
             32'h0000_0000};
    wtab = '{18'h0_0000, 18'h0_8000, 18'h1_0000, 18'h3_0000, 18'h1_0000, 18'h0_0000};
    etab = '{16'h0000, 16'h8000, 16'hFFFF, 16'h0000, 16'hFFFF, 16'h8000};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    settle(0);
    chk(32'(filter_rate_word), 32'h0000_0045);
    rd(`SDC_OFS_RATE); chk(rdat, 32'h0000_0045);
    chk({31'h0, rerr}, 32'h0000_0000);
    wr(`SDC_OFS_RATE, 32'h0000_000D); rd(`SDC_OFS_RATE); chk(rdat, 32'h0000_000D);
    chk(32'(filter_rate_word), 32'h0000_000D);
    rd(12'h030); chk({31'h0, rerr}, 32'h0000_0001); chk(rdat, 32'h0000_0000);
    wr(12'h030, 32'h0000_00FF); chk({31'h0, rerr}, 32'h0000_0001);
    $display("test reset and map done");

    // first result needs two filter outputs, bipolar zero is midscale
    pulse(2'b01, 1); rd(`SDC_OFS_STATUS); chk(rdat & 32'h1, 32'h0000_0000);
    pulse(2'b01, 1); rd(`SDC_OFS_STATUS); chk(rdat & 32'h1, 32'h0000_0001);
    rd(`SDC_OFS_PRIM_DATA); chk(rdat, 32'h0000_8000);
    $display("test first result done");

    // settings apply only at the next conversion boundary
    wr(`SDC_OFS_PRIM_CTRL, 32'h0000_001D); settle(2);
    chk(32'(prim_cfg), 32'h0000_0000);
    pulse(2'b01, 1); settle(0); chk(32'(prim_cfg), 32'h0000_001D);
    wr(`SDC_OFS_AUX_CTRL, 32'h0000_001F); pulse(2'b10, 1); settle(0);
    chk(32'(aux_cfg), 32'h0000_0018);
    for (int r = 0; r < 8; r++) begin
      wr(`SDC_OFS_PRIM_CTRL, 32'(r)); pulse(2'b01, 1); settle(0);
      chk(32'(prim_cfg), 32'(r));
    end
    $display("test settings done");

    // output coding in both polarities
    for (int i = 0; i < 6; i++) begin
      wr(`SDC_OFS_PRIM_CTRL, ctab[i]);
      filt_word_prim <= wtab[i];
      pulse(2'b01, 4);
      rd(`SDC_OFS_PRIM_DATA); chk(rdat, {16'h0000, etab[i]});
    end
    // auxiliary coding: unipolar midscale, then bipolar zero
    wr(`SDC_OFS_AUX_CTRL, 32'h0000_0008);
    filt_word_aux <= 18'h0_8000;
    pulse(2'b10, 3);
    rd(`SDC_OFS_AUX_DATA);
    chk(rdat, 32'h0000_8000);
    wr(`SDC_OFS_AUX_CTRL, 32'h0000_0000);
    filt_word_aux <= 18'h0_0000;
    pulse(2'b10, 3);
    rd(`SDC_OFS_AUX_DATA);
    chk(rdat, 32'h0000_8000);
    $display("test coding done");

    // burnout and excitation routing, all combinations
    for (int v = 0; v < 32; v++) begin
      wr(`SDC_OFS_CUR_CTRL, 32'(v)); settle(2);
      chk(32'(cur_cfg), 32'(v));
      ea = 2'(v[0] & ~v[2]) + 2'(v[1] & v[3]);
      eb = 2'(v[0] & v[2]) + 2'(v[1] & ~v[3]);
      chk({30'h0, excitation_pin_a}, {30'h0, ea});
      chk({30'h0, excitation_pin_b}, {30'h0, eb});
    end
    // burnout still on: an open sensor reads full scale
    @(posedge pclk);
    filt_word_prim <= 18'h1_0000;
    pulse(2'b01, 2);
    rd(`SDC_OFS_PRIM_DATA);
    chk(rdat, 32'h0000_FFFF);
    filt_word_prim <= 18'h0_0000;
    // burnout off again for normal measurements
    wr(`SDC_OFS_CUR_CTRL, 32'h0000_0000);
    settle(2);
    chk(32'(cur_cfg), 32'h0000_0000);
    $display("test currents done");

    // reference loss: flag, read-only status, forced results
    @(posedge pclk);
    ref_below_min <= 1'b1; settle(8);
    chk({31'h0, no_valid_reference_flag}, 32'h0000_0001);
    wr(`SDC_OFS_STATUS, 32'h0000_0000); rd(`SDC_OFS_STATUS);
    chk(rdat & 32'h10, 32'h0000_0010);
    pulse(2'b01, 4); rd(`SDC_OFS_PRIM_DATA); chk(rdat, 32'h0000_FFFF);
    rd(`SDC_OFS_STATUS);
    chk(rdat & 32'h10, 32'h0000_0010);
    ref_below_min <= 1'b0; settle(8);
    chk({31'h0, no_valid_reference_flag}, 32'h0000_0000);
    @(posedge pclk);
    ref_open <= 1'b1; settle(8);
    chk({31'h0, no_valid_reference_flag}, 32'h0000_0001);
    $display("test reference done");

    // calibrations without reference keep old coefficients and flag errors
    rd(`SDC_OFS_PRIM_OFFS); keep = rdat;
    wr(`SDC_OFS_CAL_CMD, 32'h0000_0001); pulse(2'b01, 2);
    rd(`SDC_OFS_STATUS); chk(rdat & 32'h25, 32'h0000_0005);
    rd(`SDC_OFS_PRIM_OFFS); chk(rdat, keep);
    rd(`SDC_OFS_AUX_GAIN); keep = rdat;
    wr(`SDC_OFS_CAL_CMD, 32'h0000_0007); pulse(2'b10, 2);
    rd(`SDC_OFS_STATUS); chk(rdat & 32'h4A, 32'h0000_000A);
    rd(`SDC_OFS_AUX_GAIN); chk(rdat, keep);
    // valid reference: coefficient loads, error clears
    ref_open <= 1'b0; settle(8);
    wr(`SDC_OFS_CAL_CMD, 32'h0000_0003); pulse(2'b01, 2);
    rd(`SDC_OFS_STATUS); chk(rdat & 32'h25, 32'h0000_0001);
    rd(`SDC_OFS_PRIM_GAIN); chk(rdat, 32'h0000_8000);
    // range change keeps the coefficient, no new calibration needed
    wr(`SDC_OFS_PRIM_CTRL, 32'h0000_0005);
    rd(`SDC_OFS_PRIM_GAIN);
    chk(rdat, 32'h0000_8000);
    $display("test calibration done");
    final_report();
  end
endmodule : tb
